// >>> dv/wdl_cpu_model.sv
// Watchdog low-power bench: CPU side sending restart keys.
// Assumes the bench pulses go for one cycle with the key.
`timescale 1ns/1ps
module wdl_cpu_model (
    input wire logic clock,
    input wire logic go,
    input wire logic [7:0] key,
    output logic restartWrite,
    output logic [7:0] restartWdata
);
    initial begin
        restartWrite = 1'b0;
        restartWdata = 8'h00;
    end
    always @(posedge clock) begin
        restartWrite <= go;
        // Idle data toggles so a stale key is never seen as valid
        restartWdata <= go ? key : ~restartWdata;
    end
endmodule : wdl_cpu_model

// >>> dv/wdl_watchdog_tb.sv
// Watchdog low-power bench: keys, mode writes, standby gating.
// Assumes wdl_watchdog driven by wdl_cpu_model; overflow in stop is too long to run.
`timescale 1ns/1ps
module wdl_watchdog_tb;
    import wdl_pkg::*;
    logic clock = 0, rst_b = 0, opt = 0, halt = 0, stop = 0, go = 0;
    logic mw = 0, mbw = 0, rbw = 0, rw, tick, irst;
    logic [7:0] md = 0, key = 0, rd, mrd, rwd;
    logic [WDL_CNT_W-1:0] count, v;
    int mismatches = 0, checks_done = 0, n;
    always #5 clock = ~clock;
    wdl_cpu_model u_wdl_cpu_model (.clock(clock), .go(go), .key(key),
        .restartWrite(rw), .restartWdata(rwd));
    wdl_watchdog u_wdl_watchdog (.clock(clock), .rst_b(rst_b),
        .loscUnstoppableOpt(opt), .haltMode(halt), .stopMode(stop),
        .modeWrite(mw), .modeBitWrite(mbw), .modeWdata(md),
        .restartWrite(rw), .restartBitWrite(rbw), .restartWdata(rwd),
        .restartRdata(rd), .modeRdata(mrd), .count(count),
        .intervalTick(tick), .internalReset(irst));
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s exp %0h got %0h", what, exp, got);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task automatic tk(int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : tk
    task automatic boot(logic o);
        @(posedge clock);
        rst_b <= 0;
        opt <= o;
        stop <= 0;
        repeat (10) @(posedge clock);
        rst_b <= 1;
        tk(2);
    endtask : boot
    task automatic send(logic [7:0] k, logic e);
        @(posedge clock);
        go <= 1;
        key <= k;
        @(posedge clock);
        go <= 0;
        tk(1);
        chk("reset on key", e, irst);
    endtask : send
    task automatic mwr(logic [7:0] d, logic e);
        @(posedge clock);
        mw <= 1;
        md <= d;
        @(posedge clock);
        mw <= 0;
        #1;
        chk("reset on mode", e, irst);
    endtask : mwr
    task automatic bwr(logic r, logic e);
        @(posedge clock);
        if (r) rbw <= 1;
        else mbw <= 1;
        @(posedge clock);
        rbw <= 0;
        mbw <= 0;
        #1;
        chk("reset on bit write", e, irst);
    endtask : bwr
    task automatic freeze(logic s);
        @(posedge clock);
        if (s) stop <= 1;
        else halt <= 1;
        tk(3);
        v = count;
        tk(20 + $urandom % 30);
        chk("held", v, count);
        @(posedge clock);
        halt <= 0;
        stop <= 0;
        tk(40);
        chk("resumed", 1, count > v);
    endtask : freeze
    initial begin
        void'($urandom(32'h2DD5F5B2));
        boot(0);
        chk("mode", WDL_MODE_RESET, mrd);
        chk("rdata", WDL_RESTART_READ, rd);
        send(WDL_RESTART_KEY, 0);
        chk("cleared", 0, count);
        for (int i = 0; i < 6; i++) begin
            n = $urandom;
            send(n[7:0], n[7:0] != WDL_RESTART_KEY);
        end
        mwr(8'h67, 0);
        mwr(8'h6F, 1);
        chk("mode kept", 8'h67, mrd);
        bwr(1, 1);
        bwr(0, 1);
        // Late option change must not alter standby gating
        @(posedge clock);
        opt <= 1;
        freeze(0);
        freeze(1);
        boot(0);
        mwr(8'h77, 0);
        mwr(8'h60, 0);
        send(8'h00, 0);
        bwr(1, 0);
        boot(1);
        @(posedge clock);
        stop <= 1;
        tk(3);
        v = count;
        n = 0;
        for (int i = 0; i < 40; i++) begin
            tk(1);
            if (tick === 1'b1) n++;
        end
        chk("runs in stop", 1, count > v);
        chk("ticks in stop", 1, n > 0);
        report_and_stop();
    end
endmodule : wdl_watchdog_tb

// >>> hdl/wdl_pkg.sv
// Watchdog low-power behaviour: shared constants.
// Assumes a single 100 MHz system clock and one CPU write port.
package wdl_pkg;
    localparam logic [7:0] WDL_RESTART_KEY = 8'hAC;
    localparam logic [7:0] WDL_RESTART_READ = 8'h9A;
    localparam logic [7:0] WDL_MODE_RESET = 8'h67;
    localparam int WDL_SEL_LO = 3;
    localparam int WDL_STOP_BIT = 4;
    localparam int WDL_CNT_W = 18;
    localparam int WDL_LOSC_DIV_W = 4;
    localparam logic [WDL_LOSC_DIV_W-1:0] WDL_LOSC_DIV_LAST = 4'hF;
    typedef enum logic [1:0] {
        WDL_RUN,
        WDL_HALT,
        WDL_STOP
    } wdl_power_e;
endpackage : wdl_pkg

// >>> hdl/wdl_tick_div.sv
// Watchdog low-power behaviour: tick divider.
// Assumes enable is a level in the clock domain; one-cycle tick out.
`timescale 1ns/1ps
module wdl_tick_div #(
    parameter int W = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic [W-1:0] last,
    output logic tick
);
    logic [W-1:0] count;
    wire atLast = (count == last);
    assign tick = enable && atLast;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (enable) begin
            count <= atLast ? '0 : count + 1'b1;
        end
    end
endmodule : wdl_tick_div

// >>> hdl/wdl_watchdog.sv
// Watchdog low-power behaviour: counter, keys, standby gating.
// Assumes CPU strobes are one-cycle pulses synchronous to clock.
// Function
// - Unstoppable oscillator: counting continues through stop
// - Overflow during stop forces internal reset
// - Interval timer tick from divided low oscillator
// - Stoppable oscillator: pause in halt or stop
// - Resume with clock selected before standby
// - Stoppable oscillator: count held across standby unless a correct restart key clears it
// - Restart key other than ACH resets unless stopped
// - Restart register reads back 9AH
// - Second mode write resets unless stopped
`timescale 1ns/1ps
module wdl_watchdog
    import wdl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic loscUnstoppableOpt,
    input wire logic haltMode,
    input wire logic stopMode,
    input wire logic modeWrite,
    input wire logic modeBitWrite,
    input wire logic [7:0] modeWdata,
    input wire logic restartWrite,
    input wire logic restartBitWrite,
    input wire logic [7:0] restartWdata,
    output logic [7:0] restartRdata,
    output logic [7:0] modeRdata,
    output logic [WDL_CNT_W-1:0] count,
    output logic intervalTick,
    output logic internalReset
);
    logic optCaught;
    logic unstoppable;
    logic modeWritten;
    logic [7:0] modeReg;
    logic [WDL_CNT_W-1:0] next_count;
    wdl_power_e power;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            optCaught <= 1'b0;
            unstoppable <= 1'b0;
        end else if (!optCaught) begin
            optCaught <= 1'b1;
            unstoppable <= loscUnstoppableOpt;
        end
    end

    assign power = stopMode ? WDL_STOP : (haltMode ? WDL_HALT : WDL_RUN);

    wire wdStopped = modeReg[WDL_STOP_BIT];
    wire [1:0] clkSel = modeReg[WDL_SEL_LO +: 2];
    // Locked mode stops misuse from being silently ignored
    wire badKey = restartWrite && (restartWdata != WDL_RESTART_KEY);
    wire keyFault = (badKey || restartBitWrite) && !wdStopped;
    wire modeFault = ((modeWrite && modeWritten) || modeBitWrite)
        && !wdStopped;

    logic standbyGate;
    always_comb begin
        case (power)
            WDL_RUN: standbyGate = 1'b1;
            WDL_HALT: standbyGate = unstoppable;
            WDL_STOP: standbyGate = unstoppable;
            default: standbyGate = 1'b0;
        endcase
    end

    // same selection before and after standby
    wire [WDL_LOSC_DIV_W-1:0] divLast =
        WDL_LOSC_DIV_W'({clkSel, 2'b11});
    logic wdTick;
    wdl_tick_div #(.W(WDL_LOSC_DIV_W)) u_wdDiv (
        .clock(clock),
        .rst_b(rst_b),
        .enable(standbyGate && !wdStopped),
        .last(divLast),
        .tick(wdTick)
    );

    // interval tick from oscillator, runs in stop when unstoppable
    wdl_tick_div #(.W(WDL_LOSC_DIV_W)) u_itDiv (
        .clock(clock),
        .rst_b(rst_b),
        .enable(standbyGate),
        .last(WDL_LOSC_DIV_LAST),
        .tick(intervalTick)
    );

    wire restartOk = restartWrite && !badKey;
    wire overflow = wdTick && (count == '1);
    // correct key from interval interrupt restarts count
    assign next_count = restartOk ? '0 :
        (wdTick ? count + 1'b1 : count);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            modeReg <= WDL_MODE_RESET;
            modeWritten <= 1'b0;
        end else if (modeWrite && !modeWritten) begin
            modeReg <= modeWdata;
            modeWritten <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            internalReset <= 1'b0;
        end else begin
            internalReset <= overflow || keyFault || modeFault;
        end
    end

    assign restartRdata = WDL_RESTART_READ;
    assign modeRdata = modeReg;

    // helper: stop cycles without a divider tick
    // Bounded by the slowest divider period, not by one cycle
    logic [4:0] stopIdle;
    wire stopRunning = unstoppable && !wdStopped && stopMode;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stopIdle <= '0;
        end else if (!stopRunning || wdTick) begin
            stopIdle <= '0;
        end else if (stopIdle != 5'h1F) begin
            stopIdle <= stopIdle + 1'b1;
        end
    end

    sequence stop_tick_s;
        stopRunning && wdTick && !restartWrite;
    endsequence

    sequence stop_over_s;
        stopRunning && overflow;
    endsequence

    overflow_reset_a: assert property (@(posedge clock) disable iff (!rst_b)
        overflow |=> internalReset) else $error("overflow without reset");
    bad_key_a: assert property (@(posedge clock) disable iff (!rst_b)
        (badKey && !wdStopped) |=> internalReset) else $error("bad key");
    hold_halt_a: assert property (@(posedge clock) disable iff (!rst_b)
        (power != WDL_RUN && !unstoppable && !restartWrite)
        |=> count == $past(count)) else $error("count moved");
    stop_runs_a: assert property (@(posedge clock) disable iff (!rst_b)
        stopIdle <= 5'h10) else $error("stop froze");
    // count steps on each tick in stop
    stop_step_a: assert property (@(posedge clock) disable iff (!rst_b)
        stop_tick_s |=> count == $past(count) + 1'b1)
        else $error("stop count step");
    stop_overflow_a: assert property (@(posedge clock)
        disable iff (!rst_b) stop_over_s |=> internalReset)
        else $error("stop overflow without reset");
    // no watchdog tick in stoppable standby
    pause_tick_a: assert property (@(posedge clock) disable iff (!rst_b)
        (power != WDL_RUN && !unstoppable) |-> !wdTick)
        else $error("tick in standby");
    // correct key alone gives no reset
    good_key_a: assert property (@(posedge clock) disable iff (!rst_b)
        (restartOk && !restartBitWrite && !modeWrite && !modeBitWrite
        && !overflow) |=> !internalReset) else $error("reset on key");
    bit_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        ((modeBitWrite || restartBitWrite) && !wdStopped) |=> internalReset)
        else $error("bit write without reset");
    stopped_quiet_a: assert property (@(posedge clock)
        disable iff (!rst_b) wdStopped |=> !internalReset)
        else $error("reset while stopped");
    // interval tick is a single pulse
    it_single_a: assert property (@(posedge clock) disable iff (!rst_b)
        intervalTick |=> !intervalTick) else $error("interval tick long");
    // watchdog tick is a single pulse
    wd_single_a: assert property (@(posedge clock) disable iff (!rst_b)
        wdTick |=> !wdTick) else $error("watchdog tick long");
    second_write_a: assert property (@(posedge clock) disable iff (!rst_b)
        (modeWrite && modeWritten && !wdStopped) |=> internalReset)
        else $error("second mode write");
    mode_lock_a: assert property (@(posedge clock) disable iff (!rst_b)
        modeWritten |=> $stable(modeReg)) else $error("mode changed");
    opt_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
        optCaught |=> $stable(unstoppable)) else $error("option moved");
    restart_ok_a: assert property (@(posedge clock) disable iff (!rst_b)
        restartOk |=> count == '0) else $error("no restart");
    readback_a: assert property (@(posedge clock) disable iff (!rst_b)
        restartRdata == 8'h9A) else $error("bad readback");
    it_stop_a: assert property (@(posedge clock) disable iff (!rst_b)
        (stopMode && !unstoppable) |-> !intervalTick) else $error("tick");
endmodule : wdl_watchdog
